// ==== logic/skip_sub_exec.sv ====
// Executes increment-skip, nonzero-skip and subtract instructions behind an APB slave
`timescale 1ns/1ps
// How it works
// - incr_skip_if_zero writes the byte plus one back to memory and skips when the new byte is zero.
// - incr_to_acc_skip_if_zero puts the byte plus one in the accumulator, keeps memory, skips on zero.
// - Skip instructions take two instruction cycles, a taken skip advancing pc by two past the next instruction.
// - The bit form of skip_if_nonzero skips when the chosen bit is one and proceeds when it is zero.
// - The byte form of skip_if_nonzero rewrites the byte unchanged and skips when it is nonzero.
// - minus_to_acc loads the accumulator with accumulator minus byte and leaves memory alone.
// - minus_to_memory writes accumulator minus byte back into the addressed byte.
// - Subtraction clears carry on a borrow and sets it when the difference is zero or positive.
// - Subtraction updates range-exceeded, zero, half carry, carry, extended sign and extended zero flags.
module skip_sub_exec #(
  parameter int MEM_DEPTH = 256
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic busy,
  output logic skip_next,
  output logic [15:0] pc
);
  localparam int AW = $clog2(MEM_DEPTH);

  if (skip_sub_pkg::INSTR_CLKS < 1 || skip_sub_pkg::INSTR_CLKS > 16) begin : g_bad_clks
    $error("skip_sub_exec: INSTR_CLKS must lie in 1..16");
  end

  // The byte store and the address window both rely on a power-of-two depth
  if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("skip_sub_exec: MEM_DEPTH must be a power of two from 2 to 256");
  end

  typedef struct packed {
    skip_sub_pkg::exec_state_t st;
    skip_sub_pkg::instr_t ins;
    logic [7:0] acc;
    skip_sub_pkg::flags_t flg;
    logic [3:0] div;
    logic [15:0] pc;
    logic skip;
    logic bad_op;
    logic busy;
    logic [1:0] cycles;
    logic [7:0] maddr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] op_byte;
  logic [7:0] win_byte;
  logic [7:0] sub_diff;
  skip_sub_pkg::flags_t sub_flg;

  logic access;
  logic commit;
  logic tick;
  logic [7:0] inc;
  logic [7:0] next_acc;
  logic [7:0] off;

  // Refuses unmapped offsets and writes that would disturb a running instruction
  function automatic logic addr_err(input logic [7:0] a, input logic wr, input logic bsy);
    logic known;
    known = (a == skip_sub_pkg::OFF_CTRL) || (a == skip_sub_pkg::OFF_ACC) ||
            (a == skip_sub_pkg::OFF_FLAGS) || (a == skip_sub_pkg::OFF_STAT) ||
            (a == skip_sub_pkg::OFF_MADDR) || (a == skip_sub_pkg::OFF_MDATA) ||
            (a == skip_sub_pkg::OFF_PC);
    return !known || (wr && bsy && a != skip_sub_pkg::OFF_STAT);
  endfunction

  byte_store #(
    .DEPTH(MEM_DEPTH)
  ) u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(s_q.ins.addr[AW-1:0]),
    .rdata_a(op_byte),
    .raddr_b(s_q.maddr[AW-1:0]),
    .rdata_b(win_byte)
  );

  sub_flags u_sub (
    .minuend(s_q.acc),
    .subtrahend(op_byte),
    .diff(sub_diff),
    .flags(sub_flg)
  );

  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_waddr = s_q.ins.addr[AW-1:0];
    mem_wdata = 8'h00;
    next_acc = s_q.acc;
    off = paddr[7:0];
    inc = op_byte + 8'h01;
    tick = (s_q.div == skip_sub_pkg::DIV_LAST);
    // One wait state so that every answer comes from a flip-flop
    access = psel && penable && !s_q.pready;
    commit = psel && penable && s_q.pready && !s_q.pslverr;

    if (s_q.st == skip_sub_pkg::st_idle) begin
      s_d.div = 4'h0;
    end else if (tick) begin
      s_d.div = 4'h0;
    end else begin
      s_d.div = s_q.div + 4'h1;
    end

    s_d.pready = access;
    s_d.pslverr = 1'b0;
    if (access) begin
      s_d.pslverr = addr_err(off, pwrite, s_q.st != skip_sub_pkg::st_idle);
      s_d.prdata = 32'h0000_0000;
      case (off)
        skip_sub_pkg::OFF_CTRL: s_d.prdata[15:0] = {s_q.ins.addr, 1'b0, s_q.ins.bit_sel, 1'b0, s_q.ins.op};
        skip_sub_pkg::OFF_ACC: s_d.prdata[7:0] = s_q.acc;
        skip_sub_pkg::OFF_FLAGS: s_d.prdata[5:0] = s_q.flg;
        skip_sub_pkg::OFF_STAT: begin
          s_d.prdata[skip_sub_pkg::STAT_BUSY_BIT] = (s_q.st != skip_sub_pkg::st_idle);
          s_d.prdata[skip_sub_pkg::STAT_SKIP_BIT] = s_q.skip;
          s_d.prdata[skip_sub_pkg::STAT_BADOP_BIT] = s_q.bad_op;
          s_d.prdata[skip_sub_pkg::STAT_CYC_LSB +: 2] = s_q.cycles;
        end
        skip_sub_pkg::OFF_MADDR: s_d.prdata[7:0] = s_q.maddr;
        skip_sub_pkg::OFF_MDATA: s_d.prdata[7:0] = win_byte;
        skip_sub_pkg::OFF_PC: s_d.prdata[15:0] = s_q.pc;
        default: s_d.prdata = 32'h0000_0000;
      endcase
      // A refused access returns zero so no register contents leak out with the error
      if (s_d.pslverr) begin
        s_d.prdata = 32'h0000_0000;
      end
    end

    // Register writes; busy-time writes were already refused above
    if (commit && pwrite) begin
      case (off)
        skip_sub_pkg::OFF_CTRL: begin
          s_d.ins.op = pwdata[skip_sub_pkg::CTRL_OP_LSB +: 3];
          s_d.ins.bit_sel = pwdata[skip_sub_pkg::CTRL_BIT_LSB +: 3];
          s_d.ins.addr = pwdata[skip_sub_pkg::CTRL_ADDR_LSB +: 8];
          s_d.st = skip_sub_pkg::st_first;
          s_d.div = 4'h0;
          s_d.cycles = 2'd0;
        end
        skip_sub_pkg::OFF_ACC: s_d.acc = pwdata[7:0];
        skip_sub_pkg::OFF_FLAGS: s_d.flg = pwdata[5:0];
        skip_sub_pkg::OFF_MADDR: s_d.maddr = pwdata[7:0];
        skip_sub_pkg::OFF_MDATA: begin
          mem_we = 1'b1;
          mem_waddr = s_q.maddr[AW-1:0];
          mem_wdata = pwdata[7:0];
        end
        skip_sub_pkg::OFF_PC: s_d.pc = pwdata[15:0];
        default: s_d.pc = s_q.pc;
      endcase
    end

    case (s_q.st)
      skip_sub_pkg::st_idle: s_d.div = 4'h0;
      skip_sub_pkg::st_first: begin
        if (tick) begin
          s_d.cycles = 2'd1;
          s_d.skip = 1'b0;
          s_d.bad_op = 1'b0;
          // Skip forms move on to a second instruction cycle
          s_d.st = skip_sub_pkg::st_second;
          case (s_q.ins.op)
            skip_sub_pkg::OP_INCR_SKIP_IF_ZERO: begin
              mem_we = 1'b1;
              mem_wdata = inc;
              s_d.skip = (inc == 8'h00);
            end
            skip_sub_pkg::OP_INCR_TO_ACC_SKIP_IF_ZERO: begin
              next_acc = inc;
              s_d.skip = (inc == 8'h00);
            end
            skip_sub_pkg::OP_SKIP_IF_NONZERO_BIT: begin
              s_d.skip = op_byte[s_q.ins.bit_sel];
            end
            skip_sub_pkg::OP_SKIP_IF_NONZERO: begin
              // Read-modify-write with the same value
              mem_we = 1'b1;
              mem_wdata = op_byte;
              s_d.skip = (op_byte != 8'h00);
            end
            skip_sub_pkg::OP_MINUS_TO_ACC: begin
              next_acc = sub_diff;
              s_d.flg = sub_flg;
              s_d.st = skip_sub_pkg::st_idle;
            end
            skip_sub_pkg::OP_MINUS_TO_MEMORY: begin
              mem_we = 1'b1;
              mem_wdata = sub_diff;
              s_d.flg = sub_flg;
              s_d.st = skip_sub_pkg::st_idle;
            end
            default: begin
              // Unknown codes act as a one-cycle no-op
              s_d.bad_op = 1'b1;
              s_d.st = skip_sub_pkg::st_idle;
            end
          endcase
          s_d.acc = next_acc;
          if (s_d.st == skip_sub_pkg::st_idle) begin
            s_d.pc = s_q.pc + 16'h0001;
          end
        end
      end
      skip_sub_pkg::st_second: begin
        // Flags are never written here, so skips keep them intact
        if (tick) begin
          s_d.cycles = 2'd2;
          s_d.st = skip_sub_pkg::st_idle;
          // A taken skip steps over the following instruction
          s_d.pc = s_q.pc + (s_q.skip ? 16'h0002 : 16'h0001);
        end
      end
      default: s_d.st = skip_sub_pkg::st_idle;
    endcase

    // Kept in its own flip-flop so the pin carries no decode glue
    s_d.busy = (s_d.st != skip_sub_pkg::st_idle);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.st <= skip_sub_pkg::st_idle;
      s_q.ins <= '0;
      s_q.acc <= skip_sub_pkg::ACC_RST;
      s_q.flg <= skip_sub_pkg::FLAGS_RST;
      s_q.div <= 4'h0;
      s_q.pc <= skip_sub_pkg::PC_RST;
      s_q.skip <= 1'b0;
      s_q.bad_op <= 1'b0;
      s_q.busy <= 1'b0;
      s_q.cycles <= 2'd0;
      s_q.maddr <= 8'h00;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign prdata = s_q.prdata;
  assign busy = s_q.busy;
  assign skip_next = s_q.skip;
  assign pc = s_q.pc;
endmodule // skip_sub_exec

// ==== logic/skip_sub_pkg.sv ====
// Shared constants and types for the skip and subtract execution block
package skip_sub_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MADDR = 8'h10;
  localparam logic [7:0] OFF_MDATA = 8'h14;
  localparam logic [7:0] OFF_PC = 8'h18;

  // Control register field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BIT_LSB = 4;
  localparam int CTRL_ADDR_LSB = 8;

  // Status register field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam int STAT_BADOP_BIT = 2;
  localparam int STAT_CYC_LSB = 4;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [15:0] PC_RST = 16'h0000;

  // Timing: pclk cycles per instruction cycle
  localparam int INSTR_CLKS = 4;
  localparam logic [3:0] DIV_LAST = 4'(INSTR_CLKS - 1);

  // Instruction codes written into the control register
  localparam logic [2:0] OP_INCR_SKIP_IF_ZERO = 3'h0;
  localparam logic [2:0] OP_INCR_TO_ACC_SKIP_IF_ZERO = 3'h1;
  localparam logic [2:0] OP_SKIP_IF_NONZERO_BIT = 3'h2;
  localparam logic [2:0] OP_SKIP_IF_NONZERO = 3'h3;
  localparam logic [2:0] OP_MINUS_TO_ACC = 3'h4;
  localparam logic [2:0] OP_MINUS_TO_MEMORY = 3'h5;

  typedef enum logic [1:0] {st_idle, st_first, st_second} exec_state_t;

  // Bit 0 is carry, bit 5 is the extended zero flag
  typedef struct packed {
    logic extended_zero_flag;
    logic extended_sign_flag;
    logic arith_range_exceeded_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } flags_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [2:0] op;
  } instr_t;

endpackage

// ==== logic/byte_store.sv ====
// Data memory with two asynchronous read ports and one write port
`timescale 1ns/1ps
module byte_store #(
  parameter int DEPTH = 256
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [$clog2(DEPTH)-1:0] raddr_b,
  output logic [7:0] rdata_b
);
  logic [7:0] mem [DEPTH];

  if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_store: DEPTH must be a power of two from 2 to 256");
  end

  // No reset: memory contents are undefined until software loads them
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule // byte_store

// ==== logic/sub_flags.sv ====
// Eight-bit subtractor with status flag generation
`timescale 1ns/1ps
module sub_flags (
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output skip_sub_pkg::flags_t flags
);
  logic [8:0] wide;
  logic z;
  logic ov;

  always_comb begin
    wide = {1'b0, minuend} - {1'b0, subtrahend};
    diff = wide[7:0];
    z = (wide[7:0] == 8'h00);
    ov = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]);
    flags.carry_flag = ~wide[8];
    flags.half_carry_flag = ~(minuend[3:0] < subtrahend[3:0]);
    flags.zero_flag = z;
    flags.arith_range_exceeded_flag = ov;
    // Signed less-than view of the result
    flags.extended_sign_flag = ov ^ wide[7];
    flags.extended_zero_flag = z;
  end
endmodule // sub_flags

// ==== verification/skip_sub_exec_asserts.sv ====
// Port-level assertions for the skip and subtract block
`timescale 1ns/1ps
module skip_sub_exec_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic busy,
  input wire logic skip_next,
  input wire logic [15:0] pc
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic pcw;
  assign pcw = pready && pwrite && paddr[7:0] == skip_sub_pkg::OFF_PC;
  // Only an unrefused CTRL commit starts an instruction
  sequence s_go;
    psel && penable && pready && pwrite && !pslverr && paddr[7:0] == skip_sub_pkg::OFF_CTRL;
  endsequence
  sequence s_sub;
    s_go ##0 pwdata[2:1] == 2'h2;
  endsequence
  sequence s_skp;
    s_go ##0 !pwdata[2];
  endsequence
  property p_rdy;
    psel && penable && !pready |=> pready;
  endproperty
  property p_one;
    pready |=> !pready;
  endproperty
  property p_err;
    pready && pslverr |-> prdata == 32'h0;
  endproperty
  property p_sub;
    s_sub |=> busy [*4] ##1 !busy;
  endproperty
  property p_spc;
    s_sub |-> ##5 pc == $past(pc, 5) + 16'h1;
  endproperty
  property p_skp;
    s_skp |=> busy [*8] ##1 !busy;
  endproperty
  property p_kpc;
    s_skp |-> ##9 pc == $past(pc, 9) + (skip_next ? 16'h2 : 16'h1);
  endproperty
  property p_hold;
    $changed(skip_next) |-> $past(busy);
  endproperty
  property p_pcw;
    $changed(pc) |-> $past(busy) || $past(pcw);
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  a_one: assert property (p_one) else $error("pready too long");
  a_err: assert property (p_err) else $error("refused read data not zero");
  a_sub: assert property (p_sub) else $error("subtract length wrong");
  a_spc: assert property (p_spc) else $error("subtract pc step wrong");
  a_skp: assert property (p_skp) else $error("skip length wrong");
  a_kpc: assert property (p_kpc) else $error("skip pc step wrong");
  a_hold: assert property (p_hold) else $error("skip changed while idle");
  a_pcw: assert property (p_pcw) else $error("pc changed without cause");
endmodule // skip_sub_exec_asserts

bind skip_sub_exec skip_sub_exec_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .busy, .skip_next, .pc);

// ==== verification/tb_skip_sub_exec.sv ====
// Self-checking random test of the skip and subtract block
`timescale 1ns/1ps
module tb_skip_sub_exec;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic busy;
  logic skip_next;
  logic [15:0] pc;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 76780;

  always #12.5 pclk = ~pclk;

  skip_sub_exec i_skip_sub_exec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .busy, .skip_next, .pc);

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic hang(input string s);
    chk(32'h0, 32'h1, s);
    tally_and_finish();
  endtask

  // Request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) hang("no pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'h0, a, 32'h0);
    chk(rd, e, s);
  endtask

  // Polls status so the next CTRL write is never refused
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'h0, skip_sub_pkg::OFF_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 20);
    if (rd[0] !== 1'h0) hang("busy stuck");
  endtask

  function automatic logic [5:0] sf(input logic [7:0] a, input logic [7:0] m);
    logic [8:0] d;
    logic ov;
    d = {1'h0, a} - {1'h0, m};
    ov = (a[7] != m[7]) && (d[7] != a[7]);
    return {d[7:0] == 8'h0, ov ^ d[7], ov, d[7:0] == 8'h0, a[3:0] >= m[3:0], !d[8]};
  endfunction

  initial begin
    logic [7:0] m, a, ad, ea, em;
    logic [5:0] fl, ef;
    logic [15:0] pv, ep;
    logic [2:0] op, b;
    logic sk;
    sk = 1'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rdc(skip_sub_pkg::OFF_ACC, 32'h0, "acc reset");
    rdc(skip_sub_pkg::OFF_FLAGS, 32'h0, "flags reset");
    rdc(skip_sub_pkg::OFF_PC, 32'h0, "pc reset");
    for (int i = 0; i < 48; i++) begin
      op = 3'(i % 6);
      m = (i < 6) ? ((i < 2) ? 8'hff : 8'h00) : 8'($random(seed));
      a = 8'($random(seed));
      fl = 6'($random(seed));
      pv = 16'($random(seed));
      b = 3'($random(seed));
      ad = 8'($random(seed));
      apb(1'h1, skip_sub_pkg::OFF_MADDR, {24'h0, ad});
      apb(1'h1, skip_sub_pkg::OFF_MDATA, {24'h0, m});
      apb(1'h1, skip_sub_pkg::OFF_ACC, {24'h0, a});
      apb(1'h1, skip_sub_pkg::OFF_FLAGS, {26'h0, fl});
      apb(1'h1, skip_sub_pkg::OFF_PC, {16'h0, pv});
      em = m;
      ea = a;
      ef = fl;
      // Every instruction rewrites the skip decision, subtracts leave it clear
      sk = 1'h0;
      case (op)
        3'h0: begin
          em = m + 8'h1;
          sk = em == 8'h0;
        end
        3'h1: begin
          ea = m + 8'h1;
          sk = ea == 8'h0;
        end
        3'h2: sk = m[b];
        3'h3: sk = m != 8'h0;
        3'h4: begin
          ea = a - m;
          ef = sf(a, m);
        end
        default: begin
          em = a - m;
          ef = sf(a, m);
        end
      endcase
      ep = pv + ((op < 3'h4 && sk) ? 16'h2 : 16'h1);
      apb(1'h1, skip_sub_pkg::OFF_CTRL, {16'h0, ad, 1'h0, b, 1'h0, op});
      idle();
      rdc(skip_sub_pkg::OFF_ACC, {24'h0, ea}, "acc");
      rdc(skip_sub_pkg::OFF_FLAGS, {26'h0, ef}, "flags");
      rdc(skip_sub_pkg::OFF_MDATA, {24'h0, em}, "memory");
      rdc(skip_sub_pkg::OFF_PC, {16'h0, ep}, "pc");
      apb(1'h0, skip_sub_pkg::OFF_STAT, 32'h0);
      chk({26'h0, rd[5:0]}, {26'h0, (op < 3'h4) ? 2'h2 : 2'h1, 2'h0, sk, 1'h0}, "status");
      chk({31'h0, skip_next}, {31'h0, sk}, "skip pin");
      $display("test %0d op %0d done", i, op);
    end
    // Writes other than to status are refused while an instruction runs
    apb(1'h1, skip_sub_pkg::OFF_CTRL, {16'h0, ad, 8'h03});
    apb(1'h1, skip_sub_pkg::OFF_ACC, 32'h5a);
    chk({31'h0, er}, 32'h1, "busy write err");
    idle();
    rdc(skip_sub_pkg::OFF_ACC, {24'h0, ea}, "acc kept");
    apb(1'h0, 8'h1c, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("test refusals done");
    // Code 7 runs as a one-cycle no-op that reports the bad code
    pv = 16'($random(seed));
    apb(1'h1, skip_sub_pkg::OFF_PC, {16'h0, pv});
    apb(1'h1, skip_sub_pkg::OFF_CTRL, {16'h0, ad, 8'h07});
    idle();
    rdc(skip_sub_pkg::OFF_PC, {16'h0, pv + 16'h1}, "bad op pc");
    rdc(skip_sub_pkg::OFF_STAT, 32'h14, "bad op status");
    chk({31'h0, skip_next}, 32'h0, "bad op skip pin");
    rdc(skip_sub_pkg::OFF_ACC, {24'h0, ea}, "bad op acc");
    $display("test bad op done");
    tally_and_finish();
  end
endmodule // tb_skip_sub_exec
